// >>> isb_defs.vh
// register offsets, field positions, widths and reset values for the serial bus status block
`ifndef ISB_DEFS_VH
`define ISB_DEFS_VH

// ======================================================================
// register offsets (word index on the plain register port)
`define ISB_ADDR_W          4
`define ISB_OFF_CONTROL     4'h0
`define ISB_OFF_STATUS      4'h1
`define ISB_OFF_RX_HOLD     4'h2
`define ISB_OFF_TX_DATA     4'h3
`define ISB_OFF_SLAVE_ADDR  4'h4
`define ISB_OFF_RELOAD      4'h5
`define ISB_OFF_IRQ_STAT    4'h6
`define ISB_OFF_IRQ_MASK    4'h7

// ======================================================================
// status register fields
`define ISB_STAT_TXFULL     0
`define ISB_STAT_RXFULL     1
`define ISB_STAT_RDIR       2
`define ISB_STAT_START      3
`define ISB_STAT_TENBIT     4
`define ISB_STAT_RO_MASK    16'h003F
`define ISB_STAT_RW_MASK    16'hFFC0

// ======================================================================
// control register fields
`define ISB_CTL_ENABLE      15
`define ISB_CTL_TENBIT      10

// ======================================================================
// interrupt status fields
`define ISB_IRQ_RX          0
`define ISB_IRQ_TX          1
`define ISB_IRQ_START       2
`define ISB_IRQ_STOP        3
`define ISB_IRQ_W           4

// ======================================================================
// widths and reset values
`define ISB_DATA_W          16
`define ISB_RELOAD_W        9
`define ISB_ZERO16          16'h0000
`define ISB_ZERO8           8'h00
`define ISB_ZERO9           9'h000
`define ISB_ZERO4           4'h0
`define ISB_ZERO3           3'h0
`define ISB_ZERO2           2'h0
`define ISB_ONE3            3'h1
`define ISB_SEVEN3          3'h7
`define ISB_ADDR_RESET      10'h000
`define ISB_RELOAD_RESET    9'h000

`endif

// >>> isb_sync.v
// two-flop synchroniser for the serial bus pins
`timescale 1ns/10ps
`default_nettype none

module isb_sync (
    input  wire clk_in,   // device clock
    input  wire rst_in,   // synchronous reset, high
    input  wire async_in, // pin level from outside
    output wire sync_out  // level safe to read
);
    // ======================================================================
    // two stages; first stage feeds only the second
    reg meta_ff;  // first stage
    reg sync_ff;  // second stage

    // sample pin, released high like an idle bus
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // isb_sync
`default_nettype wire

// >>> isb_brg.v
// bit-rate generator that reloads from software value
`timescale 1ns/10ps
`default_nettype none
`include "isb_defs.vh"

module isb_brg (
    input  wire                     clk_in,    // device clock
    input  wire                     rst_in,    // synchronous reset, high
    input  wire                     run_in,    // count while high
    input  wire [`ISB_RELOAD_W-1:0] reload_in, // reload value
    output wire                     tick_out   // one-cycle rate tick
);
    // ======================================================================
    // down counter, tick when it reaches zero then reload
    reg [`ISB_RELOAD_W-1:0] cnt_ff;  // current count
    reg                     tick_ff; // registered tick

    always @(posedge clk_in) begin
        if (rst_in || !run_in) begin
            cnt_ff  <= reload_in;
            tick_ff <= 1'b0;
        end else if (cnt_ff == `ISB_ZERO9) begin
            cnt_ff  <= reload_in;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff - {{(`ISB_RELOAD_W-1){1'b0}}, 1'b1};
            tick_ff <= 1'b0;
        end
    end

    assign tick_out = tick_ff;
endmodule // isb_brg
`default_nettype wire

// >>> isb_core.v
// serial bus status, receive double buffer, transmit register and interrupts
// ======================================================================
`timescale 1ns/10ps
`default_nettype none
`include "isb_defs.vh"

module isb_core (
    input  wire                    clk_in,          // device clock, 20 MHz
    input  wire                    rst_in,          // synchronous reset, high
    input  wire [`ISB_ADDR_W-1:0]  addr_in,         // register index
    input  wire [`ISB_DATA_W-1:0]  wdata_in,        // write data
    input  wire                    wr_in,           // write strobe
    input  wire                    rd_in,           // read strobe
    output reg  [`ISB_DATA_W-1:0]  rdata_out,       // read data, next cycle
    input  wire                    scl_in,          // clock line level
    input  wire                    sda_in,          // data line level
    output reg                     sda_oe_out,      // pull data line low
    output reg                     scl_oe_out,      // pull clock line low
    output reg                     rx_pulse_out,    // byte received pulse
    output reg                     irq_out          // level interrupt
);
    // ======================================================================
    // state codes for the byte engine
    localparam ST_IDLE = 2'b00; // waiting for start
    localparam ST_ADDR = 2'b01; // taking address byte
    localparam ST_RX   = 2'b10; // taking data bytes
    localparam ST_TX   = 2'b11; // sending data bytes

    // ======================================================================
    // pin synchronisers
    wire scl_s; // synchronised clock line
    wire sda_s; // synchronised data line

    isb_sync u_sync_scl (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (scl_in),
        .sync_out (scl_s)
    );
    isb_sync u_sync_sda (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (sda_in),
        .sync_out (sda_s)
    );

    // ======================================================================
    // registers
    reg [`ISB_DATA_W-1:0]   bus_control_reg_ff;   // control, read/write
    reg [`ISB_DATA_W-1:0]   stat_hi_ff;           // writable upper status bits
    reg                     start_seen_ff;        // start detected last
    reg                     rdir_ff;              // slave direction
    reg                     rx_full_flag_ff;      // holding register full
    reg                     tx_full_flag_ff;      // transmit register full
    reg [7:0]               rx_shifter_ff;        // hidden shift register
    reg [7:0]               rx_holding_reg_ff;    // received byte
    reg [7:0]               tx_data_reg_ff;       // byte to send
    reg [7:0]               tx_shift_ff;          // outgoing shifter
    reg [9:0]               own_slave_address_ff; // own address
    reg [`ISB_RELOAD_W-1:0] bit_rate_reload_ff;   // rate reload
    reg [`ISB_IRQ_W-1:0]    irq_stat_ff;          // sticky events
    reg [`ISB_IRQ_W-1:0]    irq_mask_ff;          // event enables
    reg [1:0]               state_ff;             // engine state
    reg [2:0]               bit_cnt_ff;           // bits taken in byte
    reg                     ack_phase_ff;         // ninth clock in progress
    reg                     ack_pend_ff;          // ack decided, waits for clock low
    reg                     ack_val_ff;           // pull data low in ninth clock
    reg                     scl_d_ff;             // previous clock level
    reg                     sda_d_ff;             // previous data level

    // ======================================================================
    // bus edge and condition detection on synchronised levels
    wire scl_rise  = scl_s & ~scl_d_ff;
    wire scl_fall  = ~scl_s & scl_d_ff;
    wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
    wire enabled   = bus_control_reg_ff[`ISB_CTL_ENABLE];
    wire ten_bit   = bus_control_reg_ff[`ISB_CTL_TENBIT];

    // decode helper, used for every register hit
    function hit;
        input [`ISB_ADDR_W-1:0] a;
        input [`ISB_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    wire wr_ctl  = wr_in & hit(addr_in, `ISB_OFF_CONTROL);
    wire wr_stat = wr_in & hit(addr_in, `ISB_OFF_STATUS);
    wire wr_tx   = wr_in & hit(addr_in, `ISB_OFF_TX_DATA);
    wire wr_addr = wr_in & hit(addr_in, `ISB_OFF_SLAVE_ADDR);
    wire wr_rel  = wr_in & hit(addr_in, `ISB_OFF_RELOAD);
    wire wr_ist  = wr_in & hit(addr_in, `ISB_OFF_IRQ_STAT);
    wire wr_imk  = wr_in & hit(addr_in, `ISB_OFF_IRQ_MASK);
    wire rd_rx   = rd_in & hit(addr_in, `ISB_OFF_RX_HOLD);

    // ======================================================================
    // bit-rate generator; tick paces clock stretching release
    wire brg_tick; // rate tick

    isb_brg u_brg (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .run_in    (enabled),
        .reload_in (bit_rate_reload_ff),
        .tick_out  (brg_tick)
    );

    // ======================================================================
    // byte engine events
    wire byte_done  = scl_rise & ~ack_phase_ff & (bit_cnt_ff == `ISB_SEVEN3);
    wire in_rx      = (state_ff == ST_ADDR) || (state_ff == ST_RX);
    // seven address bits sit in the shifter; the eighth, on the line, is read/write
    wire [6:0] rx7  = rx_shifter_ff[6:0];
    wire addr_match = ten_bit ? (rx7[6:2] == 5'b11110 && rx7[1:0] == own_slave_address_ff[9:8])
                              : (rx7 == own_slave_address_ff[6:0]);
    wire rx_load    = byte_done & (state_ff == ST_RX);
    wire tx_done    = byte_done & (state_ff == ST_TX);

    // engine: shifts bits in on rising clock, out on falling clock, acks on ninth
    always @(posedge clk_in) begin
        if (rst_in || !enabled) begin
            state_ff      <= ST_IDLE;
            bit_cnt_ff    <= `ISB_ZERO3;
            ack_phase_ff  <= 1'b0;
            rx_shifter_ff <= `ISB_ZERO8;
            tx_shift_ff   <= `ISB_ZERO8;
            rdir_ff       <= 1'b0;
            sda_oe_out    <= 1'b0;
            scl_oe_out    <= 1'b0;
            ack_pend_ff   <= 1'b0;
            ack_val_ff    <= 1'b0;
        end else if (start_det) begin
            // repeated start restarts address phase
            state_ff     <= ST_ADDR;
            bit_cnt_ff   <= `ISB_ZERO3;
            ack_phase_ff <= 1'b0;
            ack_pend_ff  <= 1'b0;
            sda_oe_out   <= 1'b0;
        end else if (stop_det) begin
            state_ff   <= ST_IDLE;
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
        end else begin
            if (scl_rise && in_rx && !ack_phase_ff) begin
                rx_shifter_ff <= {rx_shifter_ff[6:0], sda_s};
            end
            if (scl_rise && !ack_phase_ff && state_ff != ST_IDLE) begin
                bit_cnt_ff <= bit_cnt_ff + `ISB_ONE3;
            end
            // data line moves only while clock is low, else it reads as start or stop
            if (scl_fall && ack_pend_ff) begin
                ack_pend_ff  <= 1'b0;
                ack_phase_ff <= 1'b1;
                sda_oe_out   <= ack_val_ff;
            end else if (scl_fall && ack_phase_ff) begin
                // ninth clock over: next byte, or hold clock while empty
                ack_phase_ff <= 1'b0;
                sda_oe_out   <= 1'b0;
                if (state_ff == ST_TX && tx_full_flag_ff) begin
                    tx_shift_ff <= tx_data_reg_ff;
                    sda_oe_out  <= ~tx_data_reg_ff[7];
                end else if (state_ff == ST_TX) begin
                    scl_oe_out <= 1'b1;
                end
            end else if (scl_fall && state_ff == ST_TX) begin
                // next outgoing bit, low drives the line
                tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
                sda_oe_out  <= ~tx_shift_ff[6];
            end
            // master nak on the ninth clock ends a read
            if (scl_rise && ack_phase_ff && state_ff == ST_TX && sda_s) begin
                state_ff <= ST_IDLE;
            end
            if (byte_done) begin
                // decide now, drive after the eighth falling edge
                ack_pend_ff <= 1'b1;
                ack_val_ff  <= 1'b0;
                case (state_ff)
                    ST_ADDR: begin
                        if (addr_match) begin
                            rdir_ff    <= sda_s;
                            state_ff   <= sda_s ? ST_TX : ST_RX;
                            ack_val_ff <= 1'b1;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                    ST_RX: begin
                        // ack only when holding register has room
                        ack_val_ff <= ~rx_full_flag_ff;
                    end
                    default: begin
                        // transmit: ninth clock belongs to the master
                        ack_val_ff <= 1'b0;
                    end
                endcase
            end
            // stretched clock: set up first bit, then let go on a rate tick
            if (scl_oe_out && tx_full_flag_ff) begin
                tx_shift_ff <= tx_data_reg_ff;
                sda_oe_out  <= ~tx_data_reg_ff[7];
                if (brg_tick && sda_oe_out == ~tx_data_reg_ff[7]) begin
                    scl_oe_out <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // receive holding register and pulse
    always @(posedge clk_in) begin
        if (rst_in) begin
            rx_holding_reg_ff <= `ISB_ZERO8;
            rx_pulse_out      <= 1'b0;
        end else begin
            if (rx_load && !rx_full_flag_ff) begin
                rx_holding_reg_ff <= {rx_shifter_ff[6:0], sda_s};
            end
            rx_pulse_out <= rx_load & ~rx_full_flag_ff & ~rx_pulse_out;
        end
    end

    // ======================================================================
    // status flags; set wins over clear
    always @(posedge clk_in) begin
        if (rst_in) begin
            start_seen_ff   <= 1'b0;
            rx_full_flag_ff <= 1'b0;
            tx_full_flag_ff <= 1'b0;
            stat_hi_ff      <= `ISB_ZERO16;
        end else begin
            if (start_det) begin
                start_seen_ff <= 1'b1;
            end else if (stop_det) begin
                start_seen_ff <= 1'b0;
            end
            // set on load, clear on read
            if (rx_load && !rx_full_flag_ff) begin
                rx_full_flag_ff <= 1'b1;
            end else if (rd_rx) begin
                rx_full_flag_ff <= 1'b0;
            end
            // set on write, clear when sent
            if (wr_tx) begin
                tx_full_flag_ff <= 1'b1;
            end else if (tx_done) begin
                tx_full_flag_ff <= 1'b0;
            end
            if (wr_stat) begin
                stat_hi_ff <= wdata_in & `ISB_STAT_RW_MASK;
            end
        end
    end

    // ======================================================================
    // software-written registers
    always @(posedge clk_in) begin
        if (rst_in) begin
            bus_control_reg_ff   <= `ISB_ZERO16;
            tx_data_reg_ff       <= `ISB_ZERO8;
            own_slave_address_ff <= `ISB_ADDR_RESET;
            bit_rate_reload_ff   <= `ISB_RELOAD_RESET;
            irq_mask_ff          <= `ISB_ZERO4;
        end else begin
            if (wr_ctl) begin
                bus_control_reg_ff <= wdata_in;
            end
            if (wr_tx) begin
                tx_data_reg_ff <= wdata_in[7:0];
            end
            if (wr_addr) begin
                own_slave_address_ff <= wdata_in[9:0];
            end
            if (wr_rel) begin
                bit_rate_reload_ff <= wdata_in[`ISB_RELOAD_W-1:0];
            end
            if (wr_imk) begin
                irq_mask_ff <= wdata_in[`ISB_IRQ_W-1:0];
            end
        end
    end

    // ======================================================================
    // sticky interrupt events, write one clears, set wins
    wire [`ISB_IRQ_W-1:0] ev_set = {stop_det, start_det, tx_done, rx_load & ~rx_full_flag_ff};
    wire [`ISB_IRQ_W-1:0] ev_clr = wr_ist ? wdata_in[`ISB_IRQ_W-1:0] : `ISB_ZERO4;

    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_stat_ff <= `ISB_ZERO4;
            irq_out     <= 1'b0;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            irq_stat_ff <= ev_set | (irq_stat_ff & ~ev_clr);
            irq_out     <= |(irq_stat_ff & irq_mask_ff);
            scl_d_ff    <= scl_s;
            sda_d_ff    <= sda_s;
        end
    end

    // ======================================================================
    // status word assembly
    wire [`ISB_DATA_W-1:0] stat_word = (stat_hi_ff & `ISB_STAT_RW_MASK)
                                     | {11'h000, ten_bit, start_seen_ff, rdir_ff,
                                        rx_full_flag_ff, tx_full_flag_ff};

    // read data registered one cycle after strobe; unmapped reads zero
    always @(posedge clk_in) begin
        if (rst_in || !rd_in) begin
            rdata_out <= `ISB_ZERO16;
        end else if (hit(addr_in, `ISB_OFF_CONTROL)) begin
            rdata_out <= bus_control_reg_ff;
        end else if (hit(addr_in, `ISB_OFF_STATUS)) begin
            rdata_out <= stat_word;
        end else if (hit(addr_in, `ISB_OFF_RX_HOLD)) begin
            rdata_out <= {8'h00, rx_holding_reg_ff};
        end else if (hit(addr_in, `ISB_OFF_TX_DATA)) begin
            rdata_out <= {8'h00, tx_data_reg_ff};
        end else if (hit(addr_in, `ISB_OFF_SLAVE_ADDR)) begin
            rdata_out <= {6'h00, own_slave_address_ff};
        end else if (hit(addr_in, `ISB_OFF_RELOAD)) begin
            rdata_out <= {7'h00, bit_rate_reload_ff};
        end else if (hit(addr_in, `ISB_OFF_IRQ_STAT)) begin
            rdata_out <= {12'h000, irq_stat_ff};
        end else if (hit(addr_in, `ISB_OFF_IRQ_MASK)) begin
            rdata_out <= {12'h000, irq_mask_ff};
        end else begin
            rdata_out <= `ISB_ZERO16;
        end
    end
endmodule // isb_core
`default_nettype wire

// >>> isb_core_props.sv
// assertion checker for the serial bus status core
`timescale 1ns/10ps
`default_nettype none
`include "isb_defs.vh"
module isb_core_props (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_oe_out,
    input wire logic        scl_oe_out,
    input wire logic        rx_pulse_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire st_a = addr_in == `ISB_OFF_STATUS; // status selected
    wire ten_w = wdata_in[10];              // ten-bit control bit
    // ======================================================================
    // register side
    property p_st_rw;
        wr_in && st_a ##1 rd_in && st_a |=> (rdata_out & 16'hFFC0) == ($past(wdata_in, 2) & 16'hFFC0);
    endproperty
    a_st_rw: assert property (p_st_rw) else $error("status high bits lost");
    property p_bit5;
        rd_in && st_a |=> !rdata_out[5];
    endproperty
    a_bit5: assert property (p_bit5) else $error("status bit 5 not zero");
    property p_tenbit;
        wr_in && addr_in == `ISB_OFF_CONTROL ##1 rd_in && st_a |=> rdata_out[4] == $past(ten_w, 2);
    endproperty
    a_tenbit: assert property (p_tenbit) else $error("ten-bit flag wrong");
    property p_tx_set;
        wr_in && addr_in == `ISB_OFF_TX_DATA ##1 rd_in && st_a |=> rdata_out[0];
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx full not set");
    property p_rx_clr;
        rd_in && addr_in == `ISB_OFF_RX_HOLD && !rx_pulse_out ##1 rd_in && st_a && !rx_pulse_out |=> !rdata_out[1];
    endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx full not cleared");
    // ======================================================================
    // receive pulse and interrupt
    property p_rx_one;
        rx_pulse_out |=> !rx_pulse_out;
    endproperty
    a_rx_one: assert property (p_rx_one) else $error("rx pulse too long");
    property p_irq_clr;
        wr_in && addr_in == `ISB_OFF_IRQ_STAT && wdata_in[3:0] == 4'hF ##1 !rx_pulse_out |=> !irq_out;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq stays after clear");
    property p_irq_mask;
        wr_in && addr_in == `ISB_OFF_IRQ_MASK && wdata_in == 16'h0000 ##1 1'b1 |=> !irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq with zero mask");
endmodule // isb_core_props
bind isb_core isb_core_props u_props (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_in),
    .sda_in(sda_in), .sda_oe_out(sda_oe_out), .scl_oe_out(scl_oe_out),
    .rx_pulse_out(rx_pulse_out), .irq_out(irq_out));
`default_nettype wire

// >>> isb_bus_model.sv
// bus master model driving the serial bus pins
`timescale 1ns/10ps
`default_nettype none
module isb_bus_model (
    input  wire logic scl_oe_in,    // design pulls clock low
    input  wire logic sda_oe_in,    // design pulls data low
    output wire logic scl_line_out, // resolved clock line
    output wire logic sda_line_out  // resolved data line
);
    logic m_scl = 1'b1; // master clock, 1 = released
    logic m_sda = 1'b1; // master data, 1 = released
    // pull-ups: a released line reads high
    assign scl_line_out = m_scl & ~scl_oe_in;
    assign sda_line_out = m_sda & ~sda_oe_in;
    // raise clock, bounded wait while the slave stretches it
    task automatic hold_high();
        int n;
        n = 0;
        #100 m_scl = 1'b1;
        while (!scl_line_out && n < 4000) begin
            #25 n++;
        end
    endtask
    task automatic bit_w(input logic b);
        #100 m_sda = b;
        hold_high();
        #200 m_scl = 1'b0;
    endtask
    task automatic bit_r(output logic b);
        #100 m_sda = 1'b1;
        hold_high();
        #150 b = sda_line_out;
        #50 m_scl = 1'b0;
    endtask
    task automatic start();
        #200 m_sda = 1'b0;
        #200 m_scl = 1'b0;
    endtask
    task automatic stop();
        #100 m_sda = 1'b0;
        hold_high();
        #200 m_sda = 1'b1;
        #200;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_w(d[i]);
        bit_r(ack);
    endtask
    task automatic rd_byte(input logic nak, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_r(d[i]);
        bit_w(nak);
    endtask
endmodule // isb_bus_model
`default_nettype wire

// >>> tb.sv
// self-checking bench for the serial bus status core
`timescale 1ns/10ps
`default_nettype none
`include "isb_defs.vh"
module tb;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic        rd_d = 1'b0;  // read taken last edge
    wire  [15:0] rdata_out;
    wire         scl_ln, sda_ln, sda_oe, scl_oe, rx_pulse, irq;
    logic [15:0] exp_q[$];     // expected read data
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          pulses = 0;   // receive pulses seen
    logic [31:0] seed = 32'hFDA34985;
    logic [15:0] su;           // stored status high bits
    logic [7:0]  b0, b1, got;
    logic        ack;
    isb_core dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .scl_in(scl_ln), .sda_in(sda_ln),
        .sda_oe_out(sda_oe), .scl_oe_out(scl_oe), .rx_pulse_out(rx_pulse), .irq_out(irq));
    isb_bus_model bus (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_line_out(scl_ln),
        .sda_line_out(sda_ln));
    initial forever #25 clk_in = ~clk_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one bus cycle; strobes stay up for back-to-back use
    task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d);
        wr_in <= w;
        rd_in <= ~w;
        addr_in <= a;
        wdata_in <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk_in);
    endtask
    task automatic idle(input int n);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // read data stands one cycle after the strobe
    always @(posedge clk_in) begin
        if (rd_d === 1'b1) cmp(rdata_out, exp_q.pop_front());
        rd_d <= rd_in;
        if (rx_pulse === 1'b1) pulses <= pulses + 1;
    end
    initial begin
        #400000 error_cnt++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        acc(0, `ISB_OFF_STATUS, 16'h0000);
        acc(0, `ISB_OFF_CONTROL, 16'h0000);
        acc(1, 4'hA, 16'hFFFF);
        acc(0, 4'hA, 16'h0000);
        idle(1);
        $display("test 1 done");
        seed = xs(seed);
        su = seed[15:0] & `ISB_STAT_RW_MASK;
        acc(1, `ISB_OFF_STATUS, seed[15:0]);
        acc(0, `ISB_OFF_STATUS, su);
        acc(1, `ISB_OFF_CONTROL, 16'h8400);
        acc(0, `ISB_OFF_STATUS, su | 16'h0010);
        acc(1, `ISB_OFF_CONTROL, 16'h8000);
        acc(1, `ISB_OFF_SLAVE_ADDR, 16'h0052);
        acc(1, `ISB_OFF_RELOAD, 16'h0004);
        acc(1, `ISB_OFF_IRQ_MASK, 16'h0000);
        acc(0, `ISB_OFF_SLAVE_ADDR, 16'h0052);
        acc(0, `ISB_OFF_RELOAD, 16'h0004);
        idle(1);
        $display("test 2 done");
        b0 = seed[23:16];
        b1 = seed[31:24];
        bus.start();
        bus.wr_byte(8'hA4, ack);
        cmp({15'h0, ack}, 16'h0000);
        bus.wr_byte(b0, ack);
        cmp({15'h0, ack}, 16'h0000);
        idle(2);
        cmp(16'(pulses), 16'h0001);
        acc(0, `ISB_OFF_STATUS, su | 16'h000A);
        acc(0, `ISB_OFF_IRQ_STAT, 16'h0005);
        idle(2);
        cmp({15'h0, irq}, 16'h0000);
        acc(1, `ISB_OFF_IRQ_MASK, 16'h0001);
        idle(3);
        cmp({15'h0, irq}, 16'h0001);
        // holding still full: second byte is refused
        bus.wr_byte(b1, ack);
        cmp({15'h0, ack}, 16'h0001);
        cmp(16'(pulses), 16'h0001);
        idle(1);
        acc(0, `ISB_OFF_RX_HOLD, {8'h00, b0});
        acc(0, `ISB_OFF_STATUS, su | 16'h0008);
        acc(1, `ISB_OFF_IRQ_STAT, 16'h000F);
        idle(3);
        cmp({15'h0, irq}, 16'h0000);
        bus.stop();
        idle(8);
        acc(0, `ISB_OFF_STATUS, su);
        idle(1);
        $display("test 3 done");
        acc(1, `ISB_OFF_TX_DATA, {8'h00, b1});
        acc(0, `ISB_OFF_STATUS, su | 16'h0001);
        idle(1);
        bus.start();
        bus.wr_byte(8'hA5, ack);
        cmp({15'h0, ack}, 16'h0000);
        bus.rd_byte(1'b1, got);
        cmp({8'h00, got}, {8'h00, b1});
        idle(2);
        acc(0, `ISB_OFF_STATUS, su | 16'h000C);
        idle(1);
        bus.stop();
        idle(8);
        acc(0, `ISB_OFF_STATUS, su | 16'h0004);
        idle(2);
        $display("test 4 done");
        summarize();
    end
endmodule // tb
`default_nettype wire
